// >>> design/afebe_top.sv
// Purpose: analog front-end enable register bank with apb slave
// Assumes: analog results arrive synchronous to ref_clk_in
// Notes:   zero wait state slave, read data latched in setup cycle
//
// Functional notes
// - bit 15 enables transform accelerator
// - bit 14 enables waveform generator
// - bit 13 runs one temperature conversion
// - bit 12 powers sensor, readings need bit 13
// - bit 11 enables fast transimpedance amplifier
// - bit 10 enables excitation instrumentation amplifier
// - bit 9 enables excitation buffer
// - bit 8 runs conversions, else idle
// - bit 7 powers converter, run bit too
// - bit 6 powers fast dac only
// - register write alone starts conversions
// - 16-bit results, 34 selectable channels
// - low power channels may bypass filter
// - bits 15 to 5 reset to zero
// - whole register resets to 0x00080000
`timescale 1ns/1ps
module afebe_top
  import afebe_pkg::*;
#(
  parameter int TEMP_CYC = TEMP_CONV_CYC,
  parameter int ADC_CYC  = ADC_SAMPLE_CYC
)
(
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [11:0]      paddr_in,
  input  wire logic [31:0]      pwdata_in,
  input  wire logic [3:0]       pstrb_in,
  output logic      [31:0]      prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  input  wire logic [RES_W-1:0] adc_sample_in,
  input  wire logic             adc_sample_valid_in,
  input  wire logic [RES_W-1:0] temp_sample_in,
  output logic                  transform_accel_on_out,
  output logic                  wave_generator_on_out,
  output logic                  temp_sensor_power_out,
  output logic                  temp_convert_busy_out,
  output logic                  fast_transimpedance_on_out,
  output logic                  excitation_amp_on_out,
  output logic                  excitation_buffer_on_out,
  output logic                  conversion_run_out,
  output logic                  converter_power_on_out,
  output logic                  fast_dac_power_on_out,
  output logic                  high_power_ref_off_out,
  output logic                  adc_convert_out,
  output logic [CHAN_W-1:0]     channel_sel_out,
  output logic                  lp_filter_bypass_out
);

  // ****************************************
  // apb decode
  // ****************************************
  logic        hit_cfg;
  logic        hit_tres;
  logic        hit_ares;
  logic        hit_ctrl;
  logic        hit_any;
  logic        wr_acc;
  logic        rd_setup;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic [31:0] prdata_nxt;

  always_comb
  begin
    hit_cfg  = (paddr_in == OFF_CFG);
    hit_tres = (paddr_in == OFF_TEMP_RES);
    hit_ares = (paddr_in == OFF_ADC_RES);
    hit_ctrl = (paddr_in == OFF_ADC_CTRL);
    hit_any  = hit_cfg || hit_tres || hit_ares || hit_ctrl;
    wr_acc   = psel_in && penable_in && pwrite_in && hit_any;
    rd_setup = psel_in && !penable_in && !pwrite_in;
    wmask    = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    pready_out  = 1'b1;
    pslverr_out = psel_in && penable_in && !hit_any;
  end

  // ****************************************
  // temperature conversion control
  // ****************************************
  typedef enum logic [1:0]
  {
    TS_IDLE = 2'b01,
    TS_BUSY = 2'b10
  } afebe_temp_e;

  afebe_temp_e tstate_r;
  afebe_temp_e tstate_nxt;
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [6:0]  ctrl_r;
  logic [6:0]  ctrl_nxt;
  logic        temp_done;
  logic        tgo_set_wr;
  logic        temp_run;
  logic        adc_go;
  logic        adc_tick;
  logic [RES_W-1:0] temp_res;
  logic [RES_W-1:0] adc_res;
  logic        temp_valid;
  logic        adc_valid;

  // count only while go and power
  assign temp_run = (tstate_r == TS_BUSY) && cfg_r[BIT_TGO] && cfg_r[BIT_TPWR];
  afebe_cycle_timer #(
    .CYCLES (TEMP_CYC)
  ) u_temp_timer (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (temp_run),
    .tick_out   (temp_done)
  );

  always_comb
  begin
    tstate_nxt = tstate_r;
    unique case (tstate_r)
      TS_IDLE:
      begin
        // readings only with go and power
        if (cfg_r[BIT_TGO] && cfg_r[BIT_TPWR])
          tstate_nxt = TS_BUSY;
      end
      TS_BUSY:
      begin
        if (temp_done || !cfg_r[BIT_TGO] || !cfg_r[BIT_TPWR])
          tstate_nxt = TS_IDLE;
      end
      default:
      begin
        tstate_nxt = TS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      tstate_r <= TS_IDLE;
    else
      tstate_r <= tstate_nxt;
  end

  // ****************************************
  // register file
  // ****************************************
  always_comb
  begin
    cfg_nxt    = cfg_r;
    ctrl_nxt   = ctrl_r;
    tgo_set_wr = wr_acc && hit_cfg && wmask[BIT_TGO] && pwdata_in[BIT_TGO];
    if (wr_acc && hit_cfg)
      cfg_nxt = (cfg_r & ~(wmask & CFG_RW_MASK)) | (pwdata_in & wmask & CFG_RW_MASK);
    // software one write wins over hardware clear
    if (temp_done && !tgo_set_wr)
      cfg_nxt[BIT_TGO] = 1'b0;
    if (wr_acc && hit_ctrl && pstrb_in[0])
    begin
      ctrl_nxt[BIT_BYPASS] = pwdata_in[BIT_BYPASS];
      // channels above the last are ignored
      if (pwdata_in[CHAN_W-1:0] <= CHAN_MAX)
        ctrl_nxt[CHAN_W-1:0] = pwdata_in[CHAN_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cfg_r  <= CFG_RST;
      ctrl_r <= CTRL_RST;
    end
    else
    begin
      cfg_r  <= cfg_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb
  begin
    rdata = 32'h00000000;
    if (hit_cfg)
      rdata = cfg_r;
    else if (hit_tres)
      rdata = {15'h0, temp_valid, temp_res};
    else if (hit_ares)
      rdata = {15'h0, adc_valid, adc_res};
    else if (hit_ctrl)
      rdata = {25'h0, ctrl_r};
    prdata_nxt = prdata_out;
    if (rd_setup)
      prdata_nxt = rdata;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      prdata_out <= 32'h00000000;
    else
      prdata_out <= prdata_nxt;
  end

  // ****************************************
  // converter pacing and results
  // ****************************************
  always_comb
  begin
    adc_go = cfg_r[BIT_ADCPWR] && cfg_r[BIT_RUN] && !cfg_r[BIT_REFOFF];
    adc_convert_out = adc_tick;
  end

  afebe_cycle_timer #(
    .CYCLES (ADC_CYC)
  ) u_adc_timer (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (adc_go),
    .tick_out   (adc_tick)
  );

  afebe_sample_hold #(
    .W (RES_W)
  ) u_temp_hold (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .capture_in (temp_done),
    .data_in    (temp_sample_in),
    .data_out   (temp_res),
    .valid_out  (temp_valid)
  );

  afebe_sample_hold #(
    .W (RES_W)
  ) u_adc_hold (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .capture_in (adc_sample_valid_in && adc_go),
    .data_in    (adc_sample_in),
    .data_out   (adc_res),
    .valid_out  (adc_valid)
  );

  // ****************************************
  // enable outputs
  // ****************************************
  always_comb
  begin
    transform_accel_on_out     = cfg_r[BIT_ACCEL];
    wave_generator_on_out      = cfg_r[BIT_WAVE];
    temp_sensor_power_out      = cfg_r[BIT_TPWR];
    temp_convert_busy_out      = (tstate_r == TS_BUSY);
    fast_transimpedance_on_out = cfg_r[BIT_TIA];
    excitation_amp_on_out      = cfg_r[BIT_INAMP];
    excitation_buffer_on_out   = cfg_r[BIT_EXBUF];
    conversion_run_out         = cfg_r[BIT_RUN];
    converter_power_on_out     = cfg_r[BIT_ADCPWR];
    fast_dac_power_on_out      = cfg_r[BIT_DACPWR];
    high_power_ref_off_out     = cfg_r[BIT_REFOFF];
    channel_sel_out            = ctrl_r[CHAN_W-1:0];
    lp_filter_bypass_out       = ctrl_r[BIT_BYPASS];
  end

  // ****************************************
  // assertions
  // ****************************************
  localparam int AST_ADC_HI = ADC_CYC + 2;
  localparam int AST_TMP_HI = TEMP_CYC + 2;

  logic cfg_wr;
  assign cfg_wr = wr_acc && hit_cfg && (pstrb_in == 4'hF);

  AST_ACCEL_WR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cfg_wr |=> transform_accel_on_out == $past(pwdata_in[BIT_ACCEL]))
    else $error("accelerator enable not taken from write");

  AST_WAVE_ONLY: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (cfg_wr && pwdata_in[BIT_WAVE] == wave_generator_on_out)
      |=> $stable(wave_generator_on_out))
    else $error("generator enable moved without its bit");

  AST_WAVE_WR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cfg_wr |=> wave_generator_on_out == $past(pwdata_in[BIT_WAVE]))
    else $error("generator enable not taken from write");

  AST_TEMP_DONE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (temp_done && !tgo_set_wr) |=> !cfg_r[BIT_TGO] && temp_res == $past(temp_sample_in))
    else $error("temperature conversion did not finish cleanly");

  AST_TEMP_TIME: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ($rose(temp_convert_busy_out) && temp_sensor_power_out)
      |-> (temp_convert_busy_out throughout (##[1:AST_TMP_HI] temp_done))
          or ##[1:AST_TMP_HI] !cfg_r[BIT_TGO] || !temp_sensor_power_out)
    else $error("temperature conversion too slow");

  AST_TEMP_GATE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    temp_done |-> temp_sensor_power_out && cfg_r[BIT_TGO])
    else $error("temperature reading without power or go");

  AST_ADC_IDLE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !(conversion_run_out && converter_power_on_out) |-> !adc_convert_out)
    else $error("conversion while idle or unpowered");

  AST_ADC_START: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (cfg_wr && pwdata_in[BIT_RUN] && pwdata_in[BIT_ADCPWR] && !pwdata_in[BIT_REFOFF])
      |-> ##[1:AST_ADC_HI] adc_convert_out || !adc_go)
    else $error("write did not start conversions");

  AST_CHAN_RANGE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    channel_sel_out <= CHAN_MAX)
    else $error("channel select out of range");

  AST_BYPASS_WR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (wr_acc && hit_ctrl && pstrb_in[0])
      |=> lp_filter_bypass_out == $past(pwdata_in[BIT_BYPASS]))
    else $error("filter bypass not taken from write");

  AST_RESET_VAL: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $past(sys_rst_in) |-> cfg_r == CFG_RST && !adc_convert_out)
    else $error("configuration reset value wrong");

  AST_RSV_BITS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cfg_r[3:0] == 4'h0 && cfg_r[31:22] == 10'h000 && cfg_r[18:17] == 2'h0)
    else $error("reserved bits not zero");

  COV_TEMP: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $rose(temp_convert_busy_out) ##[1:AST_TMP_HI] temp_done);

  COV_ADC: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    adc_convert_out ##1 adc_sample_valid_in);

  COV_PRIO: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    temp_done && wr_acc && hit_cfg && !pwdata_in[BIT_TGO]);

endmodule

// >>> design/afebe_pkg.sv
// Purpose: shared constants of the analog front-end enable register bank
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   times in ns, counts derived from the 4 ns clock
package afebe_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] OFF_CFG      = 12'h000;
  localparam logic [11:0] OFF_TEMP_RES = 12'h004;
  localparam logic [11:0] OFF_ADC_RES  = 12'h008;
  localparam logic [11:0] OFF_ADC_CTRL = 12'h00C;

  // ****************************************
  // configuration register layout
  // ****************************************
  localparam logic [31:0] CFG_RST      = 32'h00080000;
  localparam logic [31:0] CFG_RW_MASK  = 32'h0039FFF0;
  localparam int          BIT_ACCEL    = 15;
  localparam int          BIT_WAVE     = 14;
  localparam int          BIT_TGO      = 13;
  localparam int          BIT_TPWR     = 12;
  localparam int          BIT_TIA      = 11;
  localparam int          BIT_INAMP    = 10;
  localparam int          BIT_EXBUF    = 9;
  localparam int          BIT_RUN      = 8;
  localparam int          BIT_ADCPWR   = 7;
  localparam int          BIT_DACPWR   = 6;
  localparam int          BIT_REFOFF   = 5;

  // ****************************************
  // converter control register layout
  // ****************************************
  localparam int          CHAN_W       = 6;
  localparam logic [5:0]  CHAN_MAX     = 6'h21;
  localparam int          BIT_BYPASS   = 6;
  localparam logic [6:0]  CTRL_RST     = 7'h00;
  localparam int          RES_W        = 16;
  localparam int          BIT_VALID    = 16;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int TEMP_CONV_NS   = 1000;
  localparam int ADC_SAMPLE_NS  = 1250;
  localparam int TEMP_CONV_CYC  = (TEMP_CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ADC_SAMPLE_CYC = (ADC_SAMPLE_NS * 1000) / CLK_PERIOD_PS;

endpackage

// >>> design/afebe_cycle_timer.sv
// Purpose: free counter giving a one-cycle tick every CYCLES clocks
// Assumes: run_in level, counter restarts whenever run_in drops
// Notes:   first tick comes CYCLES-1 clocks after run_in rises
`timescale 1ns/1ps
module afebe_cycle_timer
#(
  parameter int CYCLES = 250
)
(
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic run_in,
  output logic      tick_out
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  always_comb
  begin
    tick_out = run_in && (cnt_r == LAST);
    cnt_nxt  = cnt_r;
    if (!run_in || tick_out)
      cnt_nxt = '0;
    else
      cnt_nxt = cnt_r + CW'(1);
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
endmodule

// >>> design/afebe_sample_hold.sv
// Purpose: holds a converter result captured on a one-cycle strobe
// Assumes: data_in stable in the capture cycle
// Notes:   valid_out stays high once a result has been taken
`timescale 1ns/1ps
module afebe_sample_hold
#(
  parameter int W = 16
)
(
  input  wire logic         ref_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         capture_in,
  input  wire logic [W-1:0] data_in,
  output logic      [W-1:0] data_out,
  output logic              valid_out
);
  logic [W-1:0] data_nxt;
  logic         valid_nxt;

  always_comb
  begin
    data_nxt  = data_out;
    valid_nxt = valid_out;
    if (capture_in)
    begin
      data_nxt  = data_in;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      data_out  <= '0;
      valid_out <= 1'b0;
    end
    else
    begin
      data_out  <= data_nxt;
      valid_out <= valid_nxt;
    end
  end
endmodule

// >>> test/tb_afe_block_enable_register.sv
// Purpose: self-checking bench for the front-end enable register bank
// Assumes: zero wait state apb slave, short conversion counts
// Notes:   table rows first, then conversions, control and error cases
`timescale 1ns/1ps
module tb_afe_block_enable_register;
  import afebe_pkg::*;
  localparam int TCYC = 4;
  localparam int ACYC = 5;
  logic              clk;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [RES_W-1:0]  adc_smp;
  logic              adc_vld;
  logic [RES_W-1:0]  tmp_smp;
  logic [9:0]        en;
  logic              busy;
  logic              conv;
  logic [CHAN_W-1:0] chan;
  logic              byp;
  logic [31:0]       rd;
  logic              er;
  int                n_fail;
  int                check_count;
  int                k;
  logic [31:0] row_wr [12] = '{32'h8000, 32'h4000, 32'h1000, 32'h0800, 32'h0400, 32'h0200,
    32'h0100, 32'h0080, 32'h0040, 32'h0020, 32'h001F, 32'hFFFFDFFF};
  logic [31:0] row_rd [12] = '{32'h8000, 32'h4000, 32'h1000, 32'h0800, 32'h0400, 32'h0200,
    32'h0100, 32'h0080, 32'h0040, 32'h0020, 32'h0010, 32'h0039DFF0};
  logic [9:0]  row_en [12] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h010,
    10'h008, 10'h004, 10'h002, 10'h001, 10'h000, 10'h3FF};

  afebe_top #(.TEMP_CYC(TCYC), .ADC_CYC(ACYC)) i_afebe_top
  (
    .ref_clk_in                 (clk),
    .sys_rst_in                 (rst),
    .psel_in                    (psel),
    .penable_in                 (penable),
    .pwrite_in                  (pwrite),
    .paddr_in                   (paddr),
    .pwdata_in                  (pwdata),
    .pstrb_in                   (4'hF),
    .prdata_out                 (prdata),
    .pready_out                 (pready),
    .pslverr_out                (pslverr),
    .adc_sample_in              (adc_smp),
    .adc_sample_valid_in        (adc_vld),
    .temp_sample_in             (tmp_smp),
    .transform_accel_on_out     (en[9]),
    .wave_generator_on_out      (en[8]),
    .temp_sensor_power_out      (en[7]),
    .temp_convert_busy_out      (busy),
    .fast_transimpedance_on_out (en[6]),
    .excitation_amp_on_out      (en[5]),
    .excitation_buffer_on_out   (en[4]),
    .conversion_run_out         (en[3]),
    .converter_power_on_out     (en[2]),
    .fast_dac_power_on_out      (en[1]),
    .high_power_ref_off_out     (en[0]),
    .adc_convert_out            (conv),
    .channel_sel_out            (chan),
    .lp_filter_bypass_out       (byp)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer: setup, access until pready, release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // no conversion pulse over two periods
  task automatic quiet(input string nm);
    k = 0;
    repeat (2 * ACYC)
    begin
      @(posedge clk);
      if (conv !== 1'b0)
        k++;
    end
    chk(nm, 32'h0, 32'(k));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    n_fail = 0;
    check_count = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    adc_smp = 16'h0000;
    adc_vld = 1'b0;
    tmp_smp = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk("en_rst", 32'h0, 32'(en));
    rdchk("cfg_rst", OFF_CFG, CFG_RST);
    for (int i = 0; i < 12; i++)
    begin
      apb(1'b1, OFF_CFG, row_wr[i]);
      rdchk("cfg_row", OFF_CFG, row_rd[i]);
      chk("en_row", 32'(row_en[i]), 32'(en));
    end
    quiet("refoff_conv");
    // temperature conversion
    tmp_smp <= 16'hA5C3;
    apb(1'b1, OFF_CFG, 32'h3000);
    k = 0;
    while (busy !== 1'b1 && k < 10)
    begin
      @(posedge clk);
      k++;
    end
    chk("busy_rise", 32'h1, 32'(busy));
    k = 0;
    while (busy !== 1'b0 && k < TCYC + 10)
    begin
      @(posedge clk);
      k++;
    end
    chk("busy_len", 32'(TCYC), 32'(k));
    rdchk("cfg_tclr", OFF_CFG, 32'h1000);
    rdchk("temp_res", OFF_TEMP_RES, 32'h0001A5C3);
    apb(1'b1, OFF_CFG, 32'h2000);
    k = 0;
    repeat (3 * TCYC)
    begin
      @(posedge clk);
      if (busy !== 1'b0)
        k++;
    end
    chk("tgo_unpowered", 32'h0, 32'(k));
    rdchk("cfg_pend", OFF_CFG, 32'h2000);
    // converter pacing and capture
    adc_smp <= 16'h8123;
    apb(1'b1, OFF_CFG, 32'h0180);
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (conv !== 1'b1 && k < 20);
    chk("conv_delay", 32'(ACYC), 32'(k));
    adc_vld <= 1'b1;
    @(posedge clk);
    adc_vld <= 1'b0;
    rdchk("adc_res", OFF_ADC_RES, 32'h00018123);
    apb(1'b1, OFF_CFG, 32'h0080);
    quiet("idle_conv");
    apb(1'b1, OFF_CFG, 32'h0100);
    quiet("unpowered_conv");
    // channel select and filter bypass
    apb(1'b1, OFF_ADC_CTRL, 32'h21);
    rdchk("chan_max", OFF_ADC_CTRL, 32'h21);
    apb(1'b1, OFF_ADC_CTRL, 32'h62);
    rdchk("chan_over", OFF_ADC_CTRL, 32'h61);
    chk("byp_out", 32'h1, 32'(byp));
    chk("chan_out", 32'h21, 32'(chan));
    // read-only and unmapped places
    apb(1'b1, OFF_TEMP_RES, 32'h0);
    rdchk("temp_ro", OFF_TEMP_RES, 32'h0001A5C3);
    apb(1'b1, 12'h010, 32'hFFFF);
    chk("wr_err", 32'h1, 32'(er));
    rdchk("unmap_rd", 12'h010, 32'h0);
    chk("rd_err", 32'h1, 32'(er));
    // software zero lands in the done cycle
    tmp_smp <= 16'h5A3C;
    apb(1'b1, OFF_CFG, 32'h3000);
    repeat (TCYC - 2) @(posedge clk);
    apb(1'b1, OFF_CFG, 32'h1000);
    rdchk("tgo_zero_wr", OFF_CFG, 32'h1000);
    rdchk("temp_res2", OFF_TEMP_RES, 32'h00015A3C);
    // software one lands in the done cycle
    apb(1'b1, OFF_CFG, 32'h3000);
    repeat (TCYC - 2) @(posedge clk);
    apb(1'b1, OFF_CFG, 32'h3000);
    rdchk("tgo_one_wr", OFF_CFG, 32'h3000);
    chk("busy_again", 32'h1, 32'(busy));
    // reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk("en_rst2", 32'h0, 32'(en));
    rdchk("cfg_rst2", OFF_CFG, CFG_RST);
    chk("busy_rst", 32'h0, 32'(busy));
    stop_test();
  end
endmodule
